// ==== core/sib_agt.sv ====
// External agent end of the multiplexed system bus.
// Assumes the processor end follows the release and response timing.
`timescale 1ns/10ps
`include "sib_consts.svh"
module sib_agt #(
  parameter int PACE = 1,
  parameter int INDEP_LEN = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_req,
  input wire logic [35:0] wr_addr,
  input wire logic [31:0] wr_data,
  input wire logic indep_req,
  input wire logic [31:0] resp_data,
  input wire logic resp_err,
  output logic [31:0] rx_data,
  output logic rx_valid,
  output logic [31:0] rd_addr,
  output logic busy,
  sib_if.agt sif
);
  // ****************************************************************
  // Declarations and checks
  // ****************************************************************
  localparam logic [3:0] PACE_M1 = 4'(PACE - 1);
  localparam logic [4:0] INDEP_M1 = 5'(INDEP_LEN - 1);

  sib_pkg::sib_agt_s r;
  sib_pkg::sib_agt_s n;
  logic dc_id;
  logic [2:0] dc_type;
  logic [1:0] dc_prop;
  logic pv;
  logic [4:0] idx;

  if (PACE < 1 || PACE > 16 || INDEP_LEN < 1 || INDEP_LEN > 31) begin : g_chk
    $error("PACE must be 1 to 16, INDEP_LEN 1 to 31");
  end

  sib_cmd_decode u_dec (
    .cmd(sif.command_bus),
    .is_id(dc_id),
    .rtype(dc_type),
    .prop(dc_prop),
    .is_final(),
    .is_resp(),
    .is_err(),
    .null_rel()
  );

  assign pv = !sif.proc_valid_n;
  assign idx = (r.st == sib_pkg::A_GAP) ? 5'h0 : r.cnt;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    n = r;
    n.rx_valid = 1'b0;
    n.valid_n = 1'b1;
    // Processor data words are watched in every state: a request of our
    // own may be waiting for release while a block write runs
    if (pv && dc_id) begin
      n.rx_data = sif.addr_data_bus[31:0];
      n.rx_valid = 1'b1;
    end
    unique case (r.st)
      sib_pkg::A_IDLE: begin
        // A processor read leads to our response
        if (pv && !dc_id && dc_type == `SIB_TYPE_READ) begin
          n.rd_addr = sif.addr_data_bus[31:0];
          n.nw = (dc_prop == `SIB_PROP_BLOCK) ? 5'(`SIB_BLK_WORDS) : 5'h1;
          n.kind = sib_pkg::K_RESP;
          n.st = sib_pkg::A_GAP;
          n.busy = 1'b1;
        end else if (wr_req || indep_req) begin
          n.waddr = wr_addr;
          n.wdat = wr_data;
          n.kind = wr_req ? sib_pkg::K_WRITE : sib_pkg::K_INDEP;
          n.ext_req_n = 1'b0;
          n.st = sib_pkg::A_REQ;
          n.busy = 1'b1;
        end
      end
      sib_pkg::A_REQ: if (!sif.bus_release_n) n.st = sib_pkg::A_GAP;
      sib_pkg::A_GAP, sib_pkg::A_RESP: begin
        // First drive lands two cycles after the release pulse
        n.cmd_oe = 1'b1;
        n.ad_oe = 1'b1;
        n.ext_req_n = 1'b1;
        if (r.kind == sib_pkg::K_WRITE) begin
          n.cmd = {1'b0, `SIB_TYPE_WRITE, `SIB_PROP_WORD, `SIB_SIZE_WORD};
          n.ad = {28'h0, r.waddr};
          n.valid_n = 1'b0;
          n.st = sib_pkg::A_CMD;
        end else if (r.kind == sib_pkg::K_INDEP) begin
          // Foreign traffic; valid held low keeps the bus owned
          n.cmd = 9'h1ff;
          n.ad = 64'h0;
          n.valid_n = 1'b0;
          n.cnt = INDEP_M1;
          n.st = sib_pkg::A_INDEP;
        end else if (r.st == sib_pkg::A_RESP && r.cnt == r.nw) begin
          n.cmd_oe = 1'b0;
          n.ad_oe = 1'b0;
          n.st = sib_pkg::A_DONE;
        end else if (r.st == sib_pkg::A_RESP && r.pc != 4'h0) begin
          n.pc = r.pc - 4'h1;
        end else begin
          // Every word is response data; error only on the first
          n.cmd = {1'b1, idx != r.nw - 5'h1, 1'b0, resp_err && idx == 5'h0,
            `SIB_RSVD_ONES};
          n.ad = {32'h0, resp_data + {27'h0, idx}};
          n.valid_n = 1'b0;
          n.cnt = idx + 5'h1;
          n.pc = PACE_M1;
          n.st = sib_pkg::A_RESP;
        end
      end
      sib_pkg::A_CMD: begin
        // Single word, flagged final and not response data
        n.cmd = {1'b1, 1'b0, 1'b1, 1'b0, `SIB_RSVD_ONES};
        n.ad = {32'h0, r.wdat};
        n.valid_n = 1'b0;
        n.st = sib_pkg::A_DATA;
      end
      sib_pkg::A_DATA: begin
        n.cmd_oe = 1'b0;
        n.ad_oe = 1'b0;
        n.st = sib_pkg::A_DONE;
      end
      sib_pkg::A_INDEP: begin
        n.valid_n = 1'b0;
        if (r.cnt == 5'h0) begin
          n.cmd = {1'b0, `SIB_TYPE_NULL, `SIB_NULL_RELEASE, 3'h7};
          n.kind = sib_pkg::K_WRITE;
          n.st = sib_pkg::A_DATA;
        end else begin
          n.cnt = r.cnt - 5'h1;
        end
      end
      sib_pkg::A_DONE: begin
        n.busy = 1'b0;
        n.st = sib_pkg::A_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.st <= sib_pkg::A_IDLE;
      r.valid_n <= 1'b1;
      r.ext_req_n <= 1'b1;
      r.cmd <= 9'h1ff;
    end else begin
      r <= n;
    end
  end

  assign rx_data = r.rx_data;
  assign rx_valid = r.rx_valid;
  assign rd_addr = r.rd_addr;
  assign busy = r.busy;
  assign sif.ext_request_n = r.ext_req_n;
  assign sif.agent_valid_n = r.valid_n;
  assign sif.agt_cmd = r.cmd;
  assign sif.agt_cmd_oe = r.cmd_oe;
  assign sif.agt_ad = r.ad;
  assign sif.agt_ad_oe = r.ad_oe;
endmodule

// ==== core/sib_cmd_decode.sv ====
// Decoder of one command-bus word into command and identifier fields.
// Assumes the word is sampled only in cycles with a valid strobe.
`timescale 1ns/10ps
`include "sib_consts.svh"
module sib_cmd_decode (
  input wire logic [8:0] cmd,
  output logic is_id,
  output logic [2:0] rtype,
  output logic [1:0] prop,
  output logic is_final,
  output logic is_resp,
  output logic is_err,
  output logic null_rel
);
  // Top bit splits address cycles from data cycles
  assign is_id = cmd[`SIB_ID_BIT];
  assign rtype = cmd[7:5];
  assign prop = cmd[4:3];
  // Identifier flags are active low except the error flag
  assign is_final = !cmd[`SIB_FINAL_BIT];
  assign is_resp = !cmd[`SIB_RESP_BIT];
  assign is_err = cmd[`SIB_ERR_BIT];
  // Only the release form of the null request is honoured
  assign null_rel = !is_id && rtype == `SIB_TYPE_NULL && prop == `SIB_NULL_RELEASE;
endmodule

// ==== core/sib_consts.svh ====
// Constants of the system bus interface: field positions, encodings,
// register offsets, reset values and cycle counts.
// Assumes inclusion by bare name from any design file.
`ifndef SIB_CONSTS_SVH
`define SIB_CONSTS_SVH
// Command word fields
`define SIB_ID_BIT 8
`define SIB_FINAL_BIT 7
`define SIB_RESP_BIT 6
`define SIB_ERR_BIT 5
`define SIB_TYPE_READ 3'h0
`define SIB_TYPE_WRITE 3'h2
`define SIB_TYPE_NULL 3'h3
`define SIB_PROP_BLOCK 2'h2
`define SIB_PROP_WORD 2'h3
`define SIB_NULL_RELEASE 2'h0
`define SIB_SIZE_BLK8 3'h5
`define SIB_SIZE_WORD 3'h3
`define SIB_RSVD_ONES 5'h1f
`define SIB_IDLE_CMD 9'h0ff
// Device register reached through external writes
`define SIB_CFG_ADDR 36'hfff100000
`define SIB_CFG_PATTERN_BIT 0
`define SIB_CFG_RST 1'b0
// Controller registers on the APB side
`define SIB_REG_CTRL 12'h000
`define SIB_REG_ADDR 12'h004
`define SIB_REG_WDATA 12'h008
`define SIB_REG_STAT 12'h00c
`define SIB_REG_RDATA 12'h010
`define SIB_REG_XDATA 12'h014
`define SIB_CTRL_WREAD 0
`define SIB_CTRL_BREAD 1
`define SIB_CTRL_BWRITE 2
`define SIB_STAT_BUSERR 2
`define SIB_STAT_DIRTY 4
`define SIB_STAT_EXTWR 5
// Cycle counts
`define SIB_BLK_WORDS 8
`define SIB_SLOW_GAP 2'h2
`define SIB_TURN_GAP 2
`endif

// ==== core/sib_dev.sv ====
// Processor end of the multiplexed system bus, with an APB slave for the
// controller registers. Assumes APB master and system bus share pclk and
// that the agent keeps its half of the bus protocol.
//
// Design decision made here: the APB slave port.
`timescale 1ns/10ps
`include "sib_consts.svh"

module sib_dev #(
  parameter int BLK_WORDS = `SIB_BLK_WORDS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  sib_if.dev sif
);
  // ****************************************************************
  // Declarations and checks
  // ****************************************************************
  localparam logic [4:0] LAST_W = 5'(BLK_WORDS - 1);
  localparam logic [4:0] ALL_W = 5'(BLK_WORDS);

  sib_pkg::sib_dev_s r;
  sib_pkg::sib_dev_s n;
  logic dc_id;
  logic [2:0] dc_type;
  logic [1:0] dc_prop;
  logic dc_final;
  logic dc_resp;
  logic dc_err;
  logic dc_null;
  logic ap_rd;
  logic ap_wr;

  // Counter is five bits wide and counts up to BLK_WORDS, which the check caps at 16
  if (BLK_WORDS < 1 || BLK_WORDS > 16) begin : g_chk
    $error("BLK_WORDS must be 1 to 16");
  end

  // Decode of whatever the agent puts on the command bus
  sib_cmd_decode u_dec (
    .cmd(sif.command_bus),
    .is_id(dc_id),
    .rtype(dc_type),
    .prop(dc_prop),
    .is_final(dc_final),
    .is_resp(dc_resp),
    .is_err(dc_err),
    .null_rel(dc_null)
  );

  // APB phases: first access cycle loads read data, second completes
  assign ap_rd = psel && penable && !r.pready;
  assign ap_wr = psel && penable && pwrite && r.pready;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    n = r;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    n.release_n = 1'b1;
    n.pvalid_n = 1'b1;

    // Register read answer, registered so outputs come from flops
    if (ap_rd) begin
      n.pready = 1'b1;
      n.prdata = 32'h0;
      unique case (paddr)
        `SIB_REG_CTRL: n.prdata = {29'h0, r.go};
        `SIB_REG_ADDR: n.prdata = r.raddr;
        `SIB_REG_WDATA: n.prdata = r.wdata;
        `SIB_REG_STAT: n.prdata = {26'h0, r.ewr_seen, r.dirty, r.pattern, r.bus_err,
          r.st == sib_pkg::D_SLAVE, r.st != sib_pkg::D_IDLE || r.go != 3'h0};
        `SIB_REG_RDATA: n.prdata = r.rdata;
        `SIB_REG_XDATA: n.prdata = r.xdata;
        default: n.pslverr = 1'b1;
      endcase
    end

    // Writes land at the completing edge; status bits clear on one
    if (ap_wr) begin
      unique case (paddr)
        `SIB_REG_CTRL: n.go = r.go | pwdata[2:0];
        `SIB_REG_ADDR: n.raddr = pwdata;
        `SIB_REG_WDATA: n.wdata = pwdata;
        `SIB_REG_STAT: begin
          if (pwdata[`SIB_STAT_BUSERR]) n.bus_err = 1'b0;
          if (pwdata[`SIB_STAT_DIRTY]) n.dirty = 1'b0;
          if (pwdata[`SIB_STAT_EXTWR]) n.ewr_seen = 1'b0;
        end
        default: ;
      endcase
    end

    // Bus sequencer; its flag sets come after the clears, so sets win
    unique case (r.st)
      sib_pkg::D_IDLE: begin
        if (!sif.ext_request_n) begin
          n.release_n = 1'b0;
          n.cmd_oe = 1'b0;
          n.ad_oe = 1'b0;
          n.st = sib_pkg::D_RELEASE;
        end else if (n.go[`SIB_CTRL_WREAD] || n.go[`SIB_CTRL_BREAD]) begin
          n.blk = !n.go[`SIB_CTRL_WREAD];
          if (n.go[`SIB_CTRL_WREAD]) begin
            n.go[`SIB_CTRL_WREAD] = 1'b0;
            n.cmd = {1'b0, `SIB_TYPE_READ, `SIB_PROP_WORD, `SIB_SIZE_WORD};
          end else begin
            n.go[`SIB_CTRL_BREAD] = 1'b0;
            n.cmd = {1'b0, `SIB_TYPE_READ, `SIB_PROP_BLOCK, `SIB_SIZE_BLK8};
          end
          n.ad = {32'h0, r.raddr};
          n.pvalid_n = 1'b0;
          n.st = sib_pkg::D_RADDR;
        end else if (n.go[`SIB_CTRL_BWRITE]) begin
          n.go[`SIB_CTRL_BWRITE] = 1'b0;
          n.cmd = {1'b0, `SIB_TYPE_WRITE, `SIB_PROP_BLOCK, `SIB_SIZE_BLK8};
          n.ad = {32'h0, r.raddr};
          n.pvalid_n = 1'b0;
          n.cnt = 5'h0;
          n.gap = 2'h0;
          n.st = sib_pkg::D_WADDR;
        end
      end
      sib_pkg::D_RADDR: begin
        // After a read the processor hands the bus over by itself
        n.cmd_oe = 1'b0;
        n.ad_oe = 1'b0;
        n.rdp = 1'b1;
        n.rerr = 1'b0;
        n.st = sib_pkg::D_SLAVE;
      end
      sib_pkg::D_WADDR, sib_pkg::D_WDATA: begin
        n.st = sib_pkg::D_WDATA;
        if (r.st == sib_pkg::D_WDATA && r.cnt == ALL_W) begin
          n.cmd = `SIB_IDLE_CMD;
          n.st = sib_pkg::D_IDLE;
        end else if (r.gap == 2'h0) begin
          // One word per slot; slow pattern leaves two idle cycles
          n.cmd = {1'b1, r.cnt != LAST_W, 1'b1, 1'b0, `SIB_RSVD_ONES};
          n.ad = {32'h0, r.wdata + {27'h0, r.cnt}};
          n.pvalid_n = 1'b0;
          n.cnt = r.cnt + 5'h1;
          n.gap = r.pattern ? 2'h0 : `SIB_SLOW_GAP;
        end else begin
          n.gap = r.gap - 2'h1;
        end
      end
      sib_pkg::D_RELEASE: n.st = sib_pkg::D_SLAVE;
      sib_pkg::D_SLAVE: begin
        // Bus content counts only in cycles the agent marks valid
        if (!sif.agent_valid_n) begin
          if (!dc_id) begin
            if (dc_null) begin
              n.ext_wr = 1'b0;
              n.st = sib_pkg::D_TURN;
            end else if (dc_type == `SIB_TYPE_WRITE) begin
              n.ext_wr = 1'b1;
              n.xaddr = sif.addr_data_bus[35:0];
            end
          end else if (r.ext_wr) begin
            // Words taken until the one flagged final, each overwriting xdata; size field is not checked
            n.xdata = sif.addr_data_bus[31:0];
            n.ewr_seen = 1'b1;
            if (r.xaddr == `SIB_CFG_ADDR) n.pattern = sif.addr_data_bus[`SIB_CFG_PATTERN_BIT];
            if (dc_final) begin
              n.ext_wr = 1'b0;
              n.st = sib_pkg::D_TURN;
            end
          end else if (r.rdp && dc_resp) begin
            n.rdata = sif.addr_data_bus[31:0];
            n.rerr = r.rerr | dc_err;
            if (dc_final) begin
              n.rdp = 1'b0;
              if (r.rerr || dc_err) n.bus_err = 1'b1;
              if (r.blk) n.dirty = 1'b1;
              n.st = sib_pkg::D_TURN;
            end
          end
        end
      end
      sib_pkg::D_TURN: begin
        // One cycle of slack while the agent floats the bus
        n.cmd = `SIB_IDLE_CMD;
        n.ad = 64'h0;
        n.cmd_oe = 1'b1;
        n.ad_oe = 1'b1;
        n.st = sib_pkg::D_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.st <= sib_pkg::D_IDLE;
      r.cmd <= `SIB_IDLE_CMD;
      r.cmd_oe <= 1'b1;
      r.ad_oe <= 1'b1;
      r.pvalid_n <= 1'b1;
      r.release_n <= 1'b1;
      r.pattern <= `SIB_CFG_RST;
    end else begin
      r <= n;
    end
  end

  // ****************************************************************
  // Outputs straight from the state register
  // ****************************************************************
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign sif.bus_release_n = r.release_n;
  assign sif.proc_valid_n = r.pvalid_n;
  assign sif.dev_cmd = r.cmd;
  assign sif.dev_cmd_oe = r.cmd_oe;
  assign sif.dev_ad = r.ad;
  assign sif.dev_ad_oe = r.ad_oe;
endmodule

// ==== core/sib_if.sv ====
// Multiplexed system bus between the processor end and the agent end.
// Assumes each end drives its own copy of the shared buses with an enable.
`timescale 1ns/10ps
interface sib_if;
  logic ext_request_n;
  logic bus_release_n;
  logic agent_valid_n;
  logic proc_valid_n;
  logic [8:0] dev_cmd;
  logic dev_cmd_oe;
  logic [63:0] dev_ad;
  logic dev_ad_oe;
  logic [8:0] agt_cmd;
  logic agt_cmd_oe;
  logic [63:0] agt_ad;
  logic agt_ad_oe;
  logic [8:0] command_bus;
  logic [63:0] addr_data_bus;

  // Wire level from the enables; an undriven bus floats high
  assign command_bus = dev_cmd_oe ? dev_cmd : (agt_cmd_oe ? agt_cmd : 9'h1ff);
  assign addr_data_bus = dev_ad_oe ? dev_ad : (agt_ad_oe ? agt_ad : '1);

  modport dev (
    output bus_release_n, proc_valid_n, dev_cmd, dev_cmd_oe, dev_ad, dev_ad_oe,
    input ext_request_n, agent_valid_n, command_bus, addr_data_bus
  );
  modport agt (
    output ext_request_n, agent_valid_n, agt_cmd, agt_cmd_oe, agt_ad, agt_ad_oe,
    input bus_release_n, proc_valid_n, command_bus, addr_data_bus
  );
endinterface

// ==== core/sib_pkg.sv ====
// Types shared by both ends of the system bus interface.
// Assumes sib_consts.svh is compiled alongside.
package sib_pkg;
  typedef logic [63:0] sib_ad_t;
  typedef logic [8:0] sib_cmd_t;

  typedef enum logic [2:0] {
    D_IDLE, D_RADDR, D_WADDR, D_WDATA, D_RELEASE, D_SLAVE, D_TURN
  } sib_dev_st_e;

  typedef enum logic [2:0] {
    A_IDLE, A_REQ, A_GAP, A_CMD, A_DATA, A_INDEP, A_RESP, A_DONE
  } sib_agt_st_e;

  typedef enum logic [1:0] {K_WRITE, K_INDEP, K_RESP} sib_kind_e;

  typedef struct packed {
    sib_dev_st_e st;
    sib_cmd_t cmd;
    logic cmd_oe;
    sib_ad_t ad;
    logic ad_oe;
    logic pvalid_n;
    logic release_n;
    logic pattern;
    logic [4:0] cnt;
    logic [1:0] gap;
    logic [2:0] go;
    logic blk;
    logic rdp;
    logic rerr;
    logic ext_wr;
    logic [35:0] xaddr;
    logic bus_err;
    logic dirty;
    logic ewr_seen;
    logic [31:0] raddr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [31:0] xdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } sib_dev_s;

  typedef struct packed {
    sib_agt_st_e st;
    sib_kind_e kind;
    sib_cmd_t cmd;
    logic cmd_oe;
    sib_ad_t ad;
    logic ad_oe;
    logic valid_n;
    logic ext_req_n;
    logic [4:0] cnt;
    logic [4:0] nw;
    logic [3:0] pc;
    logic [35:0] waddr;
    logic [31:0] wdat;
    logic [31:0] rx_data;
    logic rx_valid;
    logic [31:0] rd_addr;
    logic busy;
  } sib_agt_s;
endpackage

// ==== test/sib_chk_sva.sv ====
// Checker of the wire between the processor end and the agent end.
// Assumes it sits beside the interface and sees its signals as inputs.
`timescale 1ns/10ps
module sib_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ext_request_n,
  input wire logic bus_release_n,
  input wire logic agent_valid_n,
  input wire logic proc_valid_n,
  input wire logic dev_cmd_oe,
  input wire logic dev_ad_oe,
  input wire logic agt_cmd_oe,
  input wire logic agt_ad_oe,
  input wire logic [8:0] command_bus
);
  // ****************************************
  // Sequences
  // ****************************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Agent identifier marked final, and the release null command
  sequence s_agent_final;
    !agent_valid_n && command_bus[8] && !command_bus[7];
  endsequence
  sequence s_null_rel;
    !agent_valid_n && command_bus[8:3] == 6'h0c;
  endsequence
  // One floating cycle, then the processor end drives again
  sequence s_turn;
    (!dev_cmd_oe && !agt_cmd_oe) ##1 (dev_cmd_oe && dev_ad_oe);
  endsequence

  // ****************************************
  // Assertions
  // ****************************************
  a_release_one_cycle: assert property ($fell(bus_release_n) |=> bus_release_n)
    else $error("release pulse longer than one cycle");
  a_release_floats: assert property (!bus_release_n |-> !dev_cmd_oe && !dev_ad_oe)
    else $error("processor end drives during release");
  a_release_asked: assert property ($fell(bus_release_n) |-> $past(ext_request_n) == 1'b0)
    else $error("release without a pending request");
  a_agent_start: assert property (!bus_release_n |=> !agt_cmd_oe ##1
    (agt_cmd_oe && agt_ad_oe && ext_request_n))
    else $error("agent does not take the bus two cycles after release");
  a_one_driver: assert property (!(dev_cmd_oe && agt_cmd_oe) && !(dev_ad_oe && agt_ad_oe))
    else $error("both ends drive the bus");
  a_release_latency: assert property ($fell(ext_request_n) |->
    ##[0:24] (!bus_release_n || !dev_cmd_oe))
    else $error("release latency over 24 cycles");
  a_final_turn: assert property (s_agent_final |=> s_turn)
    else $error("bus not returned after final data cycle");
  a_null_turn: assert property (s_null_rel |=> s_turn)
    else $error("bus not returned after release null");
  a_proc_cmd_type: assert property (!proc_valid_n && !command_bus[8] |->
    command_bus[7:5] inside {3'h0, 3'h2})
    else $error("processor command of a reserved type");
  a_agent_reserved: assert property (!agent_valid_n && command_bus[8] |->
    command_bus[3:0] == 4'hf)
    else $error("agent identifier reserved bits not one");
  a_proc_drives: assert property (!proc_valid_n |-> dev_cmd_oe && dev_ad_oe)
    else $error("processor strobe without driving the bus");
endmodule

// ==== test/testbench.sv ====
// Self-checking bench: both ends joined by the interface, APB driven here.
// Assumes the controller register map and response numbering of the ends.
`timescale 1ns/10ps
`include "sib_consts.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic wr_req = 1'b0;
  logic [35:0] wr_addr = 36'h0;
  logic [31:0] wr_data = 32'h0;
  logic indep_req = 1'b0;
  logic [31:0] resp_data = 32'h0;
  logic resp_err = 1'b0;
  logic [31:0] rx_data;
  logic rx_valid;
  logic [31:0] rd_addr;
  logic busy;
  logic [31:0] rq;
  logic re;
  logic [15:0] seed = 16'd27922;
  int fail_count = 0;
  int checked = 0;
  int cyc = 0;
  int rxt[$];
  logic [31:0] rxq[$];

  // ****************************************
  // Ends, checker, clock and monitor
  // ****************************************
  sib_if sif ();
  sib_dev u_sib_dev (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sif(sif));
  sib_agt #(.PACE(2), .INDEP_LEN(4)) u_sib_agt (.pclk(pclk), .presetn(presetn),
    .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data), .indep_req(indep_req),
    .resp_data(resp_data), .resp_err(resp_err), .rx_data(rx_data), .rx_valid(rx_valid),
    .rd_addr(rd_addr), .busy(busy), .sif(sif));
  sib_chk u_sib_chk (.pclk(pclk), .presetn(presetn), .ext_request_n(sif.ext_request_n),
    .bus_release_n(sif.bus_release_n), .agent_valid_n(sif.agent_valid_n),
    .proc_valid_n(sif.proc_valid_n), .dev_cmd_oe(sif.dev_cmd_oe), .dev_ad_oe(sif.dev_ad_oe),
    .agt_cmd_oe(sif.agt_cmd_oe), .agt_ad_oe(sif.agt_ad_oe), .command_bus(sif.command_bus));

  always #50 pclk = ~pclk;
  // Sampled mid-cycle so one-cycle pulses are read settled
  always @(negedge pclk) begin
    cyc++;
    if (rx_valid === 1'b1) begin
      rxq.push_back(rx_data);
      rxt.push_back(cyc);
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  function automatic logic [15:0] sib_lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task rnd(output logic [31:0] v);
    seed = sib_lfsr(seed);
    v[31:16] = seed;
    seed = sib_lfsr(seed);
    v[15:0] = seed;
  endtask
  // One APB transfer; pready and read data are taken at the edge that
  // samples pready high, and the request is released at that same edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (pready !== 1'b1) fail_count++;
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Polls pending commands, then the busy flag; bounded
  task wait_dev;
    int n;
    n = 0;
    rq = 32'h7;
    while (rq[2:0] !== 3'h0 && n < 100) begin
      apb(1'b0, `SIB_REG_CTRL, 32'h0);
      n++;
    end
    if (rq[2:0] !== 3'h0) fail_count++;
    rq = 32'h1;
    while (rq[0] !== 1'b0 && n < 200) begin
      apb(1'b0, `SIB_REG_STAT, 32'h0);
      n++;
    end
    if (rq[0] !== 1'b0) fail_count++;
  endtask
  task wait_agent;
    int n;
    n = 0;
    repeat (3) @(negedge pclk);
    while (busy !== 1'b0 && n < 400) begin
      @(negedge pclk);
      n++;
    end
    if (busy !== 1'b0) fail_count++;
  endtask
  task ext_go(input logic [35:0] a, input logic [31:0] d, input logic indep);
    @(posedge pclk);
    wr_addr <= a;
    wr_data <= d;
    wr_req <= !indep;
    indep_req <= indep;
    @(posedge pclk);
    wr_req <= 1'b0;
    indep_req <= 1'b0;
  endtask
  // Block write; step is the expected distance between words
  task blk_write(input int step);
    logic [31:0] w;
    int i;
    rnd(w);
    apb(1'b1, `SIB_REG_WDATA, w);
    rxq.delete();
    rxt.delete();
    apb(1'b1, `SIB_REG_CTRL, 32'h4);
    if (step == 3) ext_go(36'h000001000, ~w, 1'b0);
    wait_dev;
    wait_agent;
    `CHK(rxq.size(), `SIB_BLK_WORDS)
    for (i = 0; i < rxq.size(); i++) begin
      `CHK(rxq[i], w + 32'(i))
      if (i > 0) `CHK(rxt[i] - rxt[i-1], step)
    end
    apb(1'b0, `SIB_REG_XDATA, 32'h0);
    if (step == 3) `CHK(rq, ~w)
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    #(20000 * 100);
    fail_count++;
    print_verdict;
  end
  initial begin
    logic [31:0] v;
    logic [31:0] a;
    int k;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `SIB_REG_STAT, 32'h0);
    `CHK(rq[3], 1'b0)
    apb(1'b0, 12'h020, 32'h0);
    `CHK(re, 1'b1)
    // External single-word write
    rnd(v);
    ext_go({4'h0, v}, v, 1'b0);
    wait_agent;
    apb(1'b0, `SIB_REG_XDATA, 32'h0);
    `CHK(rq, v)
    apb(1'b0, `SIB_REG_STAT, 32'h0);
    `CHK(rq[5], 1'b1)
    apb(1'b1, `SIB_REG_STAT, 32'h20);
    // Word reads, clean and with a flagged error
    for (k = 0; k < 2; k++) begin
      rnd(v);
      rnd(a);
      resp_data <= v;
      resp_err <= k[0];
      apb(1'b1, `SIB_REG_ADDR, {a[31:2], 2'b00});
      apb(1'b1, `SIB_REG_CTRL, 32'h1);
      wait_dev;
      apb(1'b0, `SIB_REG_RDATA, 32'h0);
      `CHK(rq, v)
      `CHK(rd_addr, {a[31:2], 2'b00})
      apb(1'b0, `SIB_REG_STAT, 32'h0);
      `CHK(rq[2], k[0])
      apb(1'b1, `SIB_REG_STAT, 32'h4);
    end
    // Block read with an error on the first word only
    resp_err <= 1'b1;
    apb(1'b1, `SIB_REG_CTRL, 32'h2);
    wait_dev;
    apb(1'b0, `SIB_REG_STAT, 32'h0);
    `CHK(rq[4], 1'b1)
    `CHK(rq[2], 1'b1)
    apb(1'b1, `SIB_REG_STAT, 32'h14);
    apb(1'b0, `SIB_REG_STAT, 32'h0);
    `CHK(rq[2], 1'b0)
    resp_err <= 1'b0;
    // Independent transfer leaves no write behind
    ext_go(36'h0, 32'h0, 1'b1);
    wait_agent;
    apb(1'b0, `SIB_REG_STAT, 32'h0);
    `CHK(rq[5], 1'b0)
    `CHK(rq[1], 1'b0)
    // Slow pattern with a request arriving mid-block, then fast pattern
    blk_write(3);
    ext_go(`SIB_CFG_ADDR, 32'h1, 1'b0);
    wait_agent;
    apb(1'b0, `SIB_REG_STAT, 32'h0);
    `CHK(rq[3], 1'b1)
    blk_write(1);
    print_verdict;
  end
endmodule
